// file: verilog/pic_pkg.sv
/*
  Constants and types for the serial command port of the power manager.
  Assumes a 25 MHz core clock and a two-wire bus with external pull-ups.
*/

package pic_pkg;

  // bus addressing
  localparam logic [6:0] DEV_ADDR    = 7'h09;
  localparam logic [7:0] WR_ADDR     = {DEV_ADDR, 1'b0};
  localparam logic [7:0] RD_ADDR     = {DEV_ADDR, 1'b1};
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [2:0] LAST_TX_BIT = 3'h7;
  localparam int         NUM_CMD     = 4;

  // timing
  localparam int CLK_KHZ     = 25000;
  localparam int SCL_MAX_KHZ = 400;
  localparam int GLITCH_NS   = 50;
  localparam int GLITCH_CYC  = (GLITCH_NS * CLK_KHZ + 999999) / 1000000;
  localparam logic [1:0] FILT_CNT = 2'(GLITCH_CYC);
  // bus clock high phase in core clocks; must beat filter plus sync delay
  localparam int SCL_HIGH_CYC = CLK_KHZ / (SCL_MAX_KHZ * 4);

  // command transfer sequence after stop
  localparam logic [2:0] COMMIT_IDLE  = 3'h0;
  localparam logic [2:0] COMMIT_FIRST = 3'h1;
  localparam logic [2:0] COMMIT_WR0   = 3'h2;
  localparam logic [2:0] COMMIT_LAST  = 3'h5;

  // reset values
  localparam logic [7:0] CMD_RESET = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_WADR_ACK = 4'h2,
    ST_SUB      = 4'h3,
    ST_SUB_ACK  = 4'h4,
    ST_DATA     = 4'h5,
    ST_DATA_ACK = 4'h6,
    ST_RADR_ACK = 4'h7,
    ST_RD_BYTE  = 4'h8,
    ST_RD_ACK   = 4'h9,
    ST_IGNORE   = 4'hA
  } pic_state_e;

endpackage

// file: verilog/pic_hold_mem.sv
/*
  Holding store for written command bytes, one per sub-address.
  Assumes a single clock; read data appear one cycle after the address.
*/
`timescale 1ns/1ps
`default_nettype none

module pic_hold_mem (
  // clock
  input  wire logic       clk,
  // write port
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_addr,
  input  wire logic [7:0] wr_data,
  // read port
  input  wire logic [1:0] rd_addr,
  output logic      [7:0] rd_data
);

  logic [7:0] mem [0:3];

  // no reset: a pending flag elsewhere says which entries are valid
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // pic_hold_mem

`default_nettype wire

// file: verilog/pic_i2c_port.sv
/*
  Two-wire slave command port: four command bytes written through a
  sub-address, one status byte read back, commands applied at stop.
  Assumes bus pins sampled on the 25 MHz core clock, open-drain data
  resolved outside, and supply and power-down levels from analog logic.
*/
`timescale 1ns/1ps
`default_nettype none

module pic_i2c_port (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  // supply and power state
  input  wire logic       port_logic_supply_ok,
  input  wire logic       power_down_state_one,
  input  wire logic       power_down_state_two,
  // status and commands
  input  wire logic [7:0] status_byte,
  output logic      [7:0] cmd_byte_0,
  output logic      [7:0] cmd_byte_1,
  output logic      [7:0] cmd_byte_2,
  output logic      [7:0] cmd_byte_3
);

  typedef struct packed {
    logic [1:0]            scl_sy;   // [0] first flop, [1] second
    logic [1:0]            sda_sy;
    logic [1:0]            sup_sy;
    logic [1:0]            pd1_sy;
    logic [1:0]            pd2_sy;
    logic                  scl_f;
    logic                  sda_f;
    logic [1:0]            scl_cnt;
    logic [1:0]            sda_cnt;
    pic_pkg::pic_state_e   state;
    logic [3:0]            bits;
    logic [7:0]            rx;
    logic [7:0]            tx;
    logic [1:0]            sub;
    logic [3:0]            pend;
    logic [2:0]            ccnt;
    logic [3:0][7:0]       cmd;
    logic                  oe_n;
    logic                  out;
  } pic_port_s;

  logic       rst_m_reg;
  logic       rst_int_n;
  pic_port_s  q_reg;
  pic_port_s  q_next;
  logic       scl_rise, scl_fall, start_ev, stop_ev;
  logic       clr_all, clr_cmd;
  logic       mem_we;
  logic [7:0] mem_rd;
  logic [1:0] cidx;

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_reg <= 1'b0;
      rst_int_n <= 1'b0;
    end else begin
      rst_m_reg <= 1'b1;
      rst_int_n <= rst_m_reg;
    end
  end

  // bus events from filtered lines only
  assign scl_rise = q_next.scl_f & ~q_reg.scl_f;
  assign scl_fall = ~q_next.scl_f & q_reg.scl_f;
  assign start_ev = q_reg.scl_f & q_next.scl_f & q_reg.sda_f
                    & ~q_next.sda_f;
  assign stop_ev  = q_reg.scl_f & q_next.scl_f & ~q_reg.sda_f
                    & q_next.sda_f;
  assign clr_all  = ~q_reg.sup_sy[1];
  assign clr_cmd  = clr_all | q_reg.pd1_sy[1] | q_reg.pd2_sy[1];
  assign mem_we   = scl_fall & (q_reg.state == pic_pkg::ST_DATA)
                    & (q_reg.bits == pic_pkg::BYTE_BITS) & ~clr_cmd;
  assign cidx     = 2'(q_reg.ccnt - pic_pkg::COMMIT_WR0);

  pic_hold_mem u_hold (
    .clk     (clk),
    .wr_en   (mem_we),
    .wr_addr (q_reg.sub),
    .wr_data (q_reg.rx),
    .rd_addr (2'(q_reg.ccnt - pic_pkg::COMMIT_FIRST)),
    .rd_data (mem_rd)
  );

  // next state: sync, filter, byte engine, commit of held data
  always_comb begin
    q_next = q_reg;
    q_next.scl_sy = {q_reg.scl_sy[0], scl_in};
    q_next.sda_sy = {q_reg.sda_sy[0], sda_in};
    q_next.sup_sy = {q_reg.sup_sy[0], port_logic_supply_ok};
    q_next.pd1_sy = {q_reg.pd1_sy[0], power_down_state_one};
    q_next.pd2_sy = {q_reg.pd2_sy[0], power_down_state_two};
    // a level must hold FILT_CNT+1 samples; fits a 400 kHz clock
    if (q_reg.scl_sy[1] == q_reg.scl_f) begin
      q_next.scl_cnt = 2'h0;
    end else if (q_reg.scl_cnt == pic_pkg::FILT_CNT) begin
      q_next.scl_f   = q_reg.scl_sy[1];
      q_next.scl_cnt = 2'h0;
    end else begin
      q_next.scl_cnt = q_reg.scl_cnt + 2'h1;
    end
    if (q_reg.sda_sy[1] == q_reg.sda_f) begin
      q_next.sda_cnt = 2'h0;
    end else if (q_reg.sda_cnt == pic_pkg::FILT_CNT) begin
      q_next.sda_f   = q_reg.sda_sy[1];
      q_next.sda_cnt = 2'h0;
    end else begin
      q_next.sda_cnt = q_reg.sda_cnt + 2'h1;
    end

    // byte engine; drive changes only at clock fall to avoid fake start
    if (start_ev) begin
      q_next.state = pic_pkg::ST_ADDR;
      q_next.bits  = 4'h0;
      q_next.oe_n  = 1'b1;
    end else if (stop_ev) begin
      q_next.state = pic_pkg::ST_IDLE;
      q_next.oe_n  = 1'b1;
      if (q_reg.pend != 4'h0) begin
        q_next.ccnt = pic_pkg::COMMIT_FIRST;
      end
    end else if (scl_rise) begin
      case (q_reg.state)
        pic_pkg::ST_ADDR, pic_pkg::ST_SUB, pic_pkg::ST_DATA: begin
          q_next.rx   = {q_reg.rx[6:0], q_reg.sda_f};
          q_next.bits = q_reg.bits + 4'h1;
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      case (q_reg.state)
        pic_pkg::ST_ADDR: begin
          if (q_reg.bits == pic_pkg::BYTE_BITS) begin
            if (q_reg.rx == pic_pkg::WR_ADDR) begin
              q_next.state = pic_pkg::ST_WADR_ACK;
              q_next.oe_n  = 1'b0;
            end else if (q_reg.rx == pic_pkg::RD_ADDR) begin
              q_next.state = pic_pkg::ST_RADR_ACK;
              q_next.oe_n  = 1'b0;
            end else begin
              q_next.state = pic_pkg::ST_IGNORE;
            end
          end
        end
        pic_pkg::ST_SUB: begin
          if (q_reg.bits == pic_pkg::BYTE_BITS) begin
            q_next.state = pic_pkg::ST_SUB_ACK;
            q_next.sub   = q_reg.rx[1:0];
            q_next.oe_n  = 1'b0;
          end
        end
        pic_pkg::ST_DATA: begin
          if (q_reg.bits == pic_pkg::BYTE_BITS) begin
            q_next.state = pic_pkg::ST_DATA_ACK;
            q_next.oe_n  = 1'b0;
          end
        end
        pic_pkg::ST_WADR_ACK: begin
          q_next.state = pic_pkg::ST_SUB;
          q_next.bits  = 4'h0;
          q_next.oe_n  = 1'b1;
        end
        pic_pkg::ST_SUB_ACK: begin
          q_next.state = pic_pkg::ST_DATA;
          q_next.bits  = 4'h0;
          q_next.oe_n  = 1'b1;
        end
        pic_pkg::ST_DATA_ACK: begin
          // a fourth byte is outside the three-byte cycle
          q_next.state = pic_pkg::ST_IGNORE;
          q_next.oe_n  = 1'b1;
        end
        pic_pkg::ST_RADR_ACK: begin
          q_next.state = pic_pkg::ST_RD_BYTE;
          q_next.tx    = status_byte;
          q_next.bits  = 4'h0;
          q_next.oe_n  = status_byte[7];
        end
        pic_pkg::ST_RD_BYTE: begin
          if (q_reg.bits[2:0] == pic_pkg::LAST_TX_BIT) begin
            q_next.state = pic_pkg::ST_RD_ACK;
            q_next.oe_n  = 1'b1;
          end else begin
            q_next.tx   = {q_reg.tx[6:0], 1'b0};
            q_next.bits = q_reg.bits + 4'h1;
            q_next.oe_n = q_reg.tx[6];
          end
        end
        pic_pkg::ST_RD_ACK: begin
          // master answer is not looked at
          q_next.state = pic_pkg::ST_IGNORE;
        end
        default: ;
      endcase
    end

    // commit held bytes to the command latches, one per cycle
    if (q_reg.ccnt != pic_pkg::COMMIT_IDLE) begin
      if (q_reg.ccnt >= pic_pkg::COMMIT_WR0 && q_reg.pend[cidx]) begin
        q_next.cmd[cidx]  = mem_rd;
        q_next.pend[cidx] = 1'b0;
      end
      q_next.ccnt = (q_reg.ccnt == pic_pkg::COMMIT_LAST)
                    ? pic_pkg::COMMIT_IDLE : q_reg.ccnt + 3'h1;
    end
    // new data wins over the clear of its pending flag
    if (mem_we) begin
      q_next.pend[q_reg.sub] = 1'b1;
    end
    if (clr_cmd) begin
      q_next.cmd  = {pic_pkg::NUM_CMD{pic_pkg::CMD_RESET}};
      q_next.pend = 4'h0;
      q_next.ccnt = pic_pkg::COMMIT_IDLE;
    end
    if (clr_all) begin
      q_next.state = pic_pkg::ST_IDLE;
      q_next.oe_n  = 1'b1;
      q_next.bits  = 4'h0;
    end
    q_next.out = 1'b0;
  end

  // state register; filters idle high like the pulled-up bus
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      q_reg        <= '0;
      q_reg.scl_sy <= 2'h3;
      q_reg.sda_sy <= 2'h3;
      q_reg.scl_f  <= 1'b1;
      q_reg.sda_f  <= 1'b1;
      q_reg.state  <= pic_pkg::ST_IDLE;
      q_reg.oe_n   <= 1'b1;
    end else begin
      q_reg <= q_next;
    end
  end

  assign sda_out    = q_reg.out;
  assign sda_oe_n   = q_reg.oe_n;
  assign cmd_byte_0 = q_reg.cmd[0];
  assign cmd_byte_1 = q_reg.cmd[1];
  assign cmd_byte_2 = q_reg.cmd[2];
  assign cmd_byte_3 = q_reg.cmd[3];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_int_n);

  a_uv_clear_cmd: assert property (
    !q_reg.sup_sy[1] |=> q_reg.cmd == '0 && q_reg.state == pic_pkg::ST_IDLE)
    else $error("commands not cleared on low supply");
  a_filter_stable: assert property (
    $changed(q_reg.scl_f) |-> $past(q_reg.scl_sy[1], 1) == q_reg.scl_f
                             && $past(q_reg.scl_sy[1], 2) == q_reg.scl_f)
    else $error("clock accepted without stable samples");
  a_start_to_addr: assert property (
    start_ev && !clr_all |=> q_reg.state == pic_pkg::ST_ADDR
                             && q_reg.bits == 4'h0 && q_reg.oe_n)
    else $error("start did not open address phase");
  a_stop_to_idle: assert property (
    stop_ev |=> q_reg.state == pic_pkg::ST_IDLE && q_reg.oe_n)
    else $error("stop did not free the bus");
  a_stop_commits: assert property (
    stop_ev && q_reg.pend != 4'h0 && q_reg.ccnt == 3'h0 |=> ##5
      q_reg.pend == 4'h0 || clr_cmd)
    else $error("held data not applied after stop");
  a_ack_write_addr: assert property (
    scl_fall && q_reg.state == pic_pkg::ST_ADDR && q_reg.bits == 4'h8
      && q_reg.rx == pic_pkg::WR_ADDR && !start_ev && !clr_all
      |=> !q_reg.oe_n)
    else $error("write address not acknowledged");
  a_ack_stable_high: assert property (
    $changed(q_reg.oe_n) && !clr_all |-> !q_reg.scl_f || start_ev || stop_ev)
    else $error("data line changed while clock high");
  a_ignore_silent: assert property (
    q_reg.state == pic_pkg::ST_IGNORE || q_reg.state == pic_pkg::ST_RD_ACK
      |-> q_reg.oe_n)
    else $error("driving data in ignore or master ack");
  a_cmd_only_commit: assert property (
    $changed(q_reg.cmd) |-> $past(q_reg.ccnt) >= 3'h2 || $past(clr_cmd))
    else $error("command changed outside commit");

  c_write_commit: cover property (q_reg.ccnt == pic_pkg::COMMIT_LAST);
  c_read_byte:    cover property (q_reg.state == pic_pkg::ST_RD_ACK);
  c_foreign_addr: cover property (q_reg.state == pic_pkg::ST_IGNORE
                                  && $past(q_reg.state) == pic_pkg::ST_ADDR);

endmodule // pic_i2c_port

`default_nettype wire

// file: tb/pic_i2c_master.sv
/*
  Behavioural two-wire bus master for the command port bench.
  Assumes the data wire is resolved outside with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none

module pic_i2c_master (
  // bus lines
  output logic      scl,
  output logic      sda_rel,
  input  wire logic sda
);
  localparam int HALF = 1280; // 2.56 us period, below 400 kHz
  localparam int HOLD = 400;  // data moves well after the clock falls

  // idle bus: both lines released high
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // data set while clock low, line sampled mid high
  task automatic bit_io(input logic b, output logic s);
    sda_rel = b;
    #(HALF - HOLD);
    scl = 1'b1;
    #(HALF / 2);
    s = sda;
    #(HALF / 2);
    scl = 1'b0;
    #HOLD;
  endtask

  // data falls while clock high, also as repeated start
  task automatic start();
    sda_rel = 1'b1;
    #(HALF - HOLD);
    scl = 1'b1;
    #HALF;
    sda_rel = 1'b0;
    #HALF;
    scl = 1'b0;
    #HOLD;
  endtask

  // data rises while clock high, bus left free
  task automatic stop();
    sda_rel = 1'b0;
    #(HALF - HOLD);
    scl = 1'b1;
    #HALF;
    sda_rel = 1'b1;
    #HALF;
  endtask

  // eight bits msb first, ninth clock released for ack
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // read one byte, then drive our own ack or nack
  task automatic rbyte(input logic mack, output logic [7:0] d,
                       output logic s);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~mack, s);
  endtask

  // short spurious clock pulse, well under the filter span
  task automatic glitch();
    scl = 1'b1;
    #60;
    scl = 1'b0;
    #HOLD;
  endtask
endmodule // pic_i2c_master

`default_nettype wire

// file: tb/tb_pmic_i2c_command_port.sv
/*
  Self-checking bench for the serial command port, with a queue-free
  behavioural model of holding store and command latches.
  Assumes the bus master model drives the link; other inputs at negedge.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_pmic_i2c_command_port;
  logic       clk, rst_n, scl, sda_rel, a, s;
  logic       supply_ok, pd_one, pd_two, sda_out, sda_oe_n;
  logic [7:0] status, d, c0, c1, c2, c3;
  logic [7:0] hold_m [4];
  logic [7:0] cmd_m  [4];
  bit         pend_m [4];
  int         miscompares, comparisons, seed;
  // open-drain data wire with pull-up
  wire logic  sda = sda_rel & (sda_oe_n | sda_out);

  pic_i2c_master u_m (.scl(scl), .sda_rel(sda_rel), .sda(sda));

  pic_i2c_port dut (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .port_logic_supply_ok(supply_ok), .power_down_state_one(pd_one),
    .power_down_state_two(pd_two), .status_byte(status),
    .cmd_byte_0(c0), .cmd_byte_1(c1), .cmd_byte_2(c2), .cmd_byte_3(c3));

  // 25 MHz core clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk_cmds();
    chk(c0, cmd_m[0], "cmd0");
    chk(c1, cmd_m[1], "cmd1");
    chk(c2, cmd_m[2], "cmd2");
    chk(c3, cmd_m[3], "cmd3");
  endtask

  // one whole write cycle; a glitch may be thrown in before the data
  task automatic wr(input logic [7:0] sub, data, input bit g);
    u_m.wbyte(pic_pkg::WR_ADDR, a);
    chk({7'h00, a}, 8'h01, "write address ack");
    u_m.wbyte(sub, a);
    chk({7'h00, a}, 8'h01, "sub-address ack");
    if (g) u_m.glitch();
    u_m.wbyte(data, a);
    chk({7'h00, a}, 8'h01, "data ack");
    hold_m[sub[1:0]] = data;
    pend_m[sub[1:0]] = 1'b1;
  endtask

  // stop moves pending held bytes into the command latches
  task automatic apply_stop();
    u_m.stop();
    for (int i = 0; i < 4; i++) begin
      if (pend_m[i]) cmd_m[i] = hold_m[i];
      pend_m[i] = 1'b0;
    end
    repeat (20) @(posedge clk);
  endtask

  // watchdog: a hang ends the run as a mismatch
  initial begin
    #3000000;
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    rst_n = 1'b0;
    supply_ok = 1'b1;
    pd_one = 1'b0;
    pd_two = 1'b0;
    status = 8'h00;
    miscompares = 0;
    comparisons = 0;
    for (int i = 0; i < 4; i++) begin
      cmd_m[i] = 8'h00;
      pend_m[i] = 1'b0;
    end
    seed = $urandom(32'h7dd9);
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    chk_cmds();
    $display("test reset done");

    // all four subs, one rewritten; repeated start opens each cycle after the first
    for (int i = 0; i < 5; i++) begin
      u_m.start();
      wr(8'(i % 4), 8'($urandom), 1'b0);
    end
    chk_cmds();
    apply_stop();
    chk_cmds();
    $display("test write done");

    // aliased sub, then repeated start to a foreign chip
    u_m.start();
    wr(8'h05, 8'($urandom), 1'b1);
    u_m.start();
    u_m.wbyte(8'h20, a);
    chk({7'h00, a}, 8'h00, "foreign address");
    u_m.wbyte(pic_pkg::WR_ADDR, a);
    chk({7'h00, a}, 8'h00, "ignored byte");
    chk_cmds();
    apply_stop();
    chk_cmds();
    $display("test alias done");

    // a fourth byte in one write cycle is refused
    u_m.start();
    wr(8'h02, 8'($urandom), 1'b0);
    u_m.wbyte(8'($urandom), a);
    chk({7'h00, a}, 8'h00, "fourth byte");
    apply_stop();
    chk_cmds();
    $display("test length done");

    // reads with nack and ack, no stop between
    for (int k = 0; k < 2; k++) begin
      @(negedge clk);
      status = 8'($urandom);
      u_m.start();
      u_m.wbyte(pic_pkg::RD_ADDR, a);
      chk({7'h00, a}, 8'h01, "read address ack");
      u_m.rbyte(k[0], d, s);
      chk(d, status, "status byte");
      if (k == 0) chk({7'h00, s}, 8'h01, "master ack slot");
    end
    u_m.start();
    wr(8'h00, 8'($urandom), 1'b0);
    apply_stop();
    chk_cmds();
    $display("test read done");

    // each clearing source in turn after a fresh write
    for (int k = 0; k < 3; k++) begin
      u_m.start();
      wr(8'(k), 8'h80 | 8'($urandom), 1'b0);
      apply_stop();
      chk_cmds();
      @(negedge clk);
      pd_one = (k == 0);
      pd_two = (k == 1);
      supply_ok = (k != 2);
      repeat (10) @(negedge clk);
      for (int i = 0; i < 4; i++) cmd_m[i] = 8'h00;
      chk_cmds();
      pd_one = 1'b0;
      pd_two = 1'b0;
      supply_ok = 1'b1;
      repeat (10) @(negedge clk);
      chk_cmds();
    end
    $display("test clear done");
    conclude();
  end
endmodule // tb_pmic_i2c_command_port

`default_nettype wire
